//--- core/lsa_defines.svh
// register offsets, field positions and reset values for the status logic
`ifndef LSA_DEFINES_SVH
`define LSA_DEFINES_SVH

// register offsets on the serial register port
`define LSA_OFS_PRIMARY_STATUS   8'h41
`define LSA_OFS_SECONDARY_STATUS 8'h42
`define LSA_OFS_PRIMARY_MASK     8'h74
`define LSA_OFS_SECONDARY_MASK   8'h75

// primary status bit positions
`define LSA_P_SECONDARY_PENDING 7
`define LSA_P_REMOTE_TWO_TEMP   6
`define LSA_P_LOCAL_TEMP        5
`define LSA_P_REMOTE_ONE_TEMP   4
`define LSA_P_FIVE_VOLT         3
`define LSA_P_SUPPLY            2
`define LSA_P_CORE_RAIL         1
`define LSA_P_TWO_HALF_VOLT     0

// secondary status bit positions
`define LSA_S_DIODE_TWO      7
`define LSA_S_DIODE_ONE      6
`define LSA_S_FAN_FOUR_TRIP  5
`define LSA_S_FAN_THREE      4
`define LSA_S_FAN_TWO        3
`define LSA_S_FAN_ONE        2
`define LSA_S_OVERTEMP       1
`define LSA_S_TWELVE_VID     0

// comparison channel index of the twelve volt rail
`define LSA_CHAN_TWELVE_VOLT 3'h7

// reset values
`define LSA_RST_STATUS 8'h00
`define LSA_RST_MASK   8'h00
`define LSA_RST_RDATA  8'h00

`endif

//--- core/lsa_pkg.sv
// types shared by the limit status and alert logic
package lsa_pkg;

	typedef logic [7:0] lsa_byte_t;

	// whole state of the status and alert block
	typedef struct packed {
		logic [6:0] primary_status;   // sticky limit flags
		lsa_byte_t  secondary_status; // sticky fault flags
		lsa_byte_t  primary_mask;
		lsa_byte_t  secondary_mask;
		lsa_byte_t  chan_fault;       // last comparison per channel
		lsa_byte_t  rdata;
		logic       alert_n;
	} lsa_state_t;

endpackage

//--- core/lsa_limit_cmp.sv
// high and low limit comparison of one measurement
`timescale 1ns/1ns
module lsa_limit_cmp #(
	parameter int WIDTH = 8
) (
	input  wire logic [WIDTH-1:0] value_in,
	input  wire logic [WIDTH-1:0] high_in,
	input  wire logic [WIDTH-1:0] low_in,
	output logic                  out_of_limit_out
);

	// above high is strict, low limit itself already counts
	assign out_of_limit_out = (value_in > high_in) ||
		(value_in <= low_in);

endmodule

//--- core/lsa_status_alert.sv
// sticky status registers, alert masks and the active-low alert output
`timescale 1ns/1ns
`include "lsa_defines.svh"

module lsa_status_alert
	import lsa_pkg::*;
(
	input  wire logic       clk_sys_in,
	input  wire logic       sys_rst_in,
	// register port from the serial bus slave
	input  wire logic [7:0] reg_addr_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	input  wire logic [7:0] reg_wdata_in,
	output logic      [7:0] reg_rdata_out,
	// measurement values and limits from the measurement sequencer
	input  wire logic       meas_valid_in,
	input  wire logic [2:0] meas_chan_in,
	input  wire logic [7:0] meas_value_in,
	input  wire logic [7:0] meas_high_in,
	input  wire logic [7:0] meas_low_in,
	// fault levels from fan, diode and trip logic
	input  wire logic [3:0] fan_slow_in,
	input  wire logic       diode_one_fault_in,
	input  wire logic       diode_two_fault_in,
	input  wire logic       overtemp_in,
	input  wire logic       thermal_trip_in,
	input  wire logic       trip_mode_in,
	input  wire logic       vid_mode_in,
	input  wire logic       vid_change_in,
	output logic            alert_n_out
);

	lsa_state_t st;
	lsa_state_t next_st;
	logic       cmp_fault;
	logic [6:0] live_primary;
	logic [7:0] live_secondary;
	logic       rd_primary;
	logic       rd_secondary;
	logic       pending;

	lsa_limit_cmp #(
		.WIDTH (8)
	) u_cmp (
		.value_in         (meas_value_in),
		.high_in          (meas_high_in),
		.low_in           (meas_low_in),
		.out_of_limit_out (cmp_fault)
	);

	// live fault levels in status bit order
	always_comb begin
		live_primary = st.chan_fault[6:0];
		live_secondary[`LSA_S_DIODE_TWO] = diode_two_fault_in;
		live_secondary[`LSA_S_DIODE_ONE] = diode_one_fault_in;
		live_secondary[`LSA_S_FAN_FOUR_TRIP] =
			trip_mode_in ? thermal_trip_in : fan_slow_in[3];
		live_secondary[`LSA_S_FAN_THREE] = fan_slow_in[2];
		live_secondary[`LSA_S_FAN_TWO] = fan_slow_in[1];
		live_secondary[`LSA_S_FAN_ONE] = fan_slow_in[0];
		live_secondary[`LSA_S_OVERTEMP] = overtemp_in;
		live_secondary[`LSA_S_TWELVE_VID] = vid_mode_in ? vid_change_in :
			st.chan_fault[`LSA_CHAN_TWELVE_VOLT];
	end

	// read strobes per status register
	assign rd_primary = reg_rd_in &&
		(reg_addr_in == `LSA_OFS_PRIMARY_STATUS);
	assign rd_secondary = reg_rd_in &&
		(reg_addr_in == `LSA_OFS_SECONDARY_STATUS);

	// alert cause: unmasked sticky or still-live source
	assign pending =
		(|((st.primary_status | live_primary) &
			~st.primary_mask[6:0])) ||
		(!st.primary_mask[`LSA_P_SECONDARY_PENDING] &&
			(|((st.secondary_status | live_secondary) &
				~st.secondary_mask)));

	// next state of the whole block
	always_comb begin
		next_st = st;
		// latest comparison result per channel
		if (meas_valid_in) begin
			next_st.chan_fault[meas_chan_in] = cmp_fault;
		end
		// clear on read only where the fault is gone; set wins
		next_st.primary_status = (rd_primary ?
			(st.primary_status & live_primary) : st.primary_status) |
			live_primary;
		next_st.secondary_status = (rd_secondary ?
			(st.secondary_status & live_secondary) :
			st.secondary_status) | live_secondary;
		// mask register writes
		if (reg_wr_in && reg_addr_in == `LSA_OFS_PRIMARY_MASK) begin
			next_st.primary_mask = reg_wdata_in;
		end
		if (reg_wr_in && reg_addr_in == `LSA_OFS_SECONDARY_MASK) begin
			next_st.secondary_mask = reg_wdata_in;
		end
		// read data, pre-clear value; unmapped reads give zero
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				`LSA_OFS_PRIMARY_STATUS: begin
					next_st.rdata = {|st.secondary_status,
						st.primary_status};
				end
				`LSA_OFS_SECONDARY_STATUS: begin
					next_st.rdata = st.secondary_status;
				end
				`LSA_OFS_PRIMARY_MASK: begin
					next_st.rdata = st.primary_mask;
				end
				`LSA_OFS_SECONDARY_MASK: begin
					next_st.rdata = st.secondary_mask;
				end
				default: begin
					next_st.rdata = `LSA_RST_RDATA;
				end
			endcase
		end
		next_st.alert_n = !pending;
	end

	// state register
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			st.primary_status   <= 7'h00;
			st.secondary_status <= `LSA_RST_STATUS;
			st.primary_mask     <= `LSA_RST_MASK;
			st.secondary_mask   <= `LSA_RST_MASK;
			st.chan_fault       <= 8'h00;
			st.rdata            <= `LSA_RST_RDATA;
			st.alert_n          <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata_out = st.rdata;
	assign alert_n_out   = st.alert_n;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);

	a_fault_sets_bit: assert property (
		(|live_secondary) |=> ((st.secondary_status &
			$past(live_secondary)) == $past(live_secondary)))
		else $error("live secondary fault did not set status");

	a_sticky_holds: assert property (
		!rd_primary |=> ((st.primary_status &
			$past(st.primary_status)) == $past(st.primary_status)))
		else $error("primary status bit lost without a read");

	a_read_clears: assert property (
		rd_secondary |=> (st.secondary_status == $past(live_secondary)))
		else $error("secondary read did not clear ended faults");

	a_summary_bit: assert property (
		rd_primary |=> (reg_rdata_out[7] == $past(|st.secondary_status)))
		else $error("summary bit does not follow secondary status");

	a_trip_select: assert property (
		(trip_mode_in && thermal_trip_in) |=>
			st.secondary_status[`LSA_S_FAN_FOUR_TRIP])
		else $error("thermal trip not flagged in trip mode");

	a_cmp_result: assert property (
		meas_valid_in |=> (st.chan_fault[$past(meas_chan_in)] ==
			(($past(meas_value_in) > $past(meas_high_in)) ||
			($past(meas_value_in) <= $past(meas_low_in)))))
		else $error("comparison result stored wrongly");

	a_masked_quiet: assert property (
		(st.primary_mask == 8'hff && st.secondary_mask == 8'hff) |=>
			alert_n_out)
		else $error("alert asserted with every source masked");

	// a read one cycle back may already have freed the alert
	a_alert_holds: assert property (
		(!alert_n_out && !$past(rd_primary) && !$past(rd_secondary) &&
			$stable(st.primary_mask) && $stable(st.secondary_mask))
			|=> !alert_n_out)
		else $error("alert released without read or mask change");

	a_alert_release: assert property (
		!pending |=> alert_n_out)
		else $error("alert held with no unmasked cause");

	a_mask_write: assert property (
		(reg_wr_in && reg_addr_in == `LSA_OFS_SECONDARY_MASK) |=>
			(st.secondary_mask == $past(reg_wdata_in)))
		else $error("secondary mask write not taken");

	c_alert_low: cover property (alert_n_out ##1 !alert_n_out);
	c_read_clear: cover property (
		st.primary_status != 7'h00 ##1 rd_primary ##1
			st.primary_status == 7'h00);
	c_masked_set: cover property (
		st.secondary_mask[`LSA_S_FAN_ONE] && fan_slow_in[0]
			##1 alert_n_out);

endmodule

//--- bench/lsa_host_model.sv
// host side model: byte reads and writes on the strobe port
`timescale 1ns/1ns
module lsa_host_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] rdata_in,
	output logic      [7:0] addr_out,
	output logic            wr_out,
	output logic            rd_out,
	output logic      [7:0] wdata_out
);
	initial begin
		addr_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = 8'h00;
	end
	// one strobe cycle, then address and data turned over
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask
	// read data taken one cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		#1 d = rdata_in;
	endtask
	// second register only fetched when the summary bit is up
	task automatic poll(output logic [7:0] p, output logic [7:0] s);
		rd(8'h41, p);
		s = 8'h00;
		if (p[7])
			rd(8'h42, s);
	endtask
endmodule

//--- bench/test_lsa_status_alert.sv
// bench for the limit status and alert logic
`timescale 1ns/1ns
module test_lsa_status_alert;
	logic       clk_sys = 1'b0;
	logic       sys_rst = 1'b1;
	logic       mv = 1'b0;
	logic [2:0] mch = 3'h0;
	logic [7:0] mval = 8'h40;
	logic [7:0] hi = 8'h80, lo = 8'h20;
	logic [7:0] addr, wdata, rdata, p, s;
	logic       wr, rd, alert_n;
	logic [3:0] fan = 4'h0;
	logic       d1 = 1'b0, d2 = 1'b0, overtemp_flag = 1'b0, trip = 1'b0;
	logic       tmode = 1'b0, vmode = 1'b0, vchg = 1'b0;
	int         failures = 0, comparisons = 0;

	lsa_status_alert u_lsa_status_alert (.clk_sys_in(clk_sys),
		.sys_rst_in(sys_rst), .reg_addr_in(addr), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.meas_valid_in(mv), .meas_chan_in(mch), .meas_value_in(mval),
		.meas_high_in(hi), .meas_low_in(lo), .fan_slow_in(fan),
		.diode_one_fault_in(d1), .diode_two_fault_in(d2),
		.overtemp_in(overtemp_flag), .thermal_trip_in(trip), .trip_mode_in(tmode),
		.vid_mode_in(vmode), .vid_change_in(vchg), .alert_n_out(alert_n));
	lsa_host_model u_lsa_host_model (.clk_in(clk_sys), .rdata_in(rdata),
		.addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));

	initial begin
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one comparison result on a channel
	task automatic meas(input logic [2:0] c, input logic [7:0] v);
		@(posedge clk_sys);
		mv <= 1'b1;
		mch <= c;
		mval <= v;
		@(posedge clk_sys);
		mv <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	// level of one secondary fault source
	task automatic src(input int b, input logic v);
		@(posedge clk_sys);
		case (b)
			7: d2 <= v;
			6: d1 <= v;
			5: fan[3] <= v;
			4, 3, 2: fan[b-2] <= v;
			1: overtemp_flag <= v;
			8: trip <= v;
			default: vchg <= v;
		endcase
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic t_reset;
		logic [7:0] regs [4] = '{8'h42, 8'h74, 8'h75, 8'h60};
		chk(rdata, 8'h00);
		u_lsa_host_model.wr(8'h41, 8'hff);
		u_lsa_host_model.rd(8'h41, p);
		chk(p, 8'h00);
		foreach (regs[i]) begin
			u_lsa_host_model.rd(regs[i], p);
			chk(p, 8'h00);
		end
		chk({7'h00, alert_n}, 8'h01);
	endtask
	task automatic t_pri;
		for (int c = 0; c < 7; c++) begin
			meas(c[2:0], c[0] ? 8'h81 : 8'h20);
			meas(c[2:0], 8'h80);
			chk({7'h00, alert_n}, 8'h00);
			u_lsa_host_model.rd(8'h41, p);
			chk(p, 8'h01 << c);
			u_lsa_host_model.rd(8'h41, p);
			chk(p, 8'h00);
		end
	endtask
	task automatic t_live;
		meas(3'h4, 8'hff);
		u_lsa_host_model.rd(8'h41, p);
		u_lsa_host_model.rd(8'h41, p);
		chk(p, 8'h10);
		chk({7'h00, alert_n}, 8'h00);
		meas(3'h4, 8'h40);
		u_lsa_host_model.rd(8'h41, p);
		u_lsa_host_model.rd(8'h41, p);
		chk(p, 8'h00);
		// other limits: low limit itself counts, high limit itself not
		@(posedge clk_sys);
		hi <= 8'h30;
		lo <= 8'h05;
		meas(3'h4, 8'h05);
		meas(3'h4, 8'h30);
		u_lsa_host_model.rd(8'h41, p);
		chk(p, 8'h10);
		u_lsa_host_model.rd(8'h41, p);
		chk(p, 8'h00);
		@(posedge clk_sys);
		hi <= 8'h80;
		lo <= 8'h20;
	endtask
	task automatic t_sec;
		for (int b = 0; b < 10; b++) begin
			@(posedge clk_sys);
			tmode <= (b == 8);
			vmode <= (b == 9);
			if (b == 0) begin
				meas(3'h7, 8'hf0);
				meas(3'h7, 8'h50);
			end else begin
				src(b, 1'b1);
				src(b, 1'b0);
			end
			chk({7'h00, alert_n}, 8'h00);
			u_lsa_host_model.poll(p, s);
			chk(p, 8'h80);
			chk(s, 8'h01 << (b == 8 ? 5 : b == 9 ? 0 : b));
			u_lsa_host_model.rd(8'h41, p);
			chk(p, 8'h00);
			chk({7'h00, alert_n}, 8'h01);
		end
	endtask
	task automatic t_mask;
		u_lsa_host_model.wr(8'h74, 8'h7f);
		u_lsa_host_model.rd(8'h74, p);
		chk(p, 8'h7f);
		meas(3'h3, 8'hff);
		chk({7'h00, alert_n}, 8'h01);
		meas(3'h3, 8'h40);
		u_lsa_host_model.rd(8'h41, p);
		chk(p, 8'h08);
		u_lsa_host_model.wr(8'h74, 8'h80);
		src(2, 1'b1);
		chk({7'h00, alert_n}, 8'h01);
		src(2, 1'b0);
		u_lsa_host_model.poll(p, s);
		chk(s, 8'h04);
		u_lsa_host_model.wr(8'h74, 8'h00);
		u_lsa_host_model.wr(8'h75, 8'h04);
		src(4, 1'b1);
		chk({7'h00, alert_n}, 8'h00);
		src(4, 1'b0);
		src(2, 1'b1);
		u_lsa_host_model.poll(p, s);
		chk(s, 8'h14);
		// masked fan one still live, unmasked fan three cleared
		repeat (2) @(posedge clk_sys);
		chk({7'h00, alert_n}, 8'h01);
		src(2, 1'b0);
		u_lsa_host_model.poll(p, s);
		chk({7'h00, alert_n}, 8'h01);
		u_lsa_host_model.rd(8'h75, p);
		chk(p, 8'h04);
		// every source masked: alert stays high, status still sets
		u_lsa_host_model.wr(8'h74, 8'hff);
		u_lsa_host_model.wr(8'h75, 8'hff);
		src(7, 1'b1);
		chk({7'h00, alert_n}, 8'h01);
		src(7, 1'b0);
		u_lsa_host_model.poll(p, s);
		chk(s, 8'h80);
	endtask
	// reset in mid-run drops sticky state and masks
	task automatic t_rerun;
		meas(3'h5, 8'hff);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		chk({7'h00, alert_n}, 8'h01);
		u_lsa_host_model.rd(8'h41, p);
		chk(p, 8'h00);
		u_lsa_host_model.rd(8'h75, p);
		chk(p, 8'h00);
	endtask
	task automatic summarize;
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		summarize();
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_reset();
		t_pri();
		t_live();
		t_sec();
		t_mask();
		t_rerun();
		summarize();
	end
endmodule
